// file: design/fbs_defines.vh
`ifndef FBS_DEFINES_VH
`define FBS_DEFINES_VH
// ----------------------------------------------------------------
// front end constants
// ----------------------------------------------------------------
`define FBS_FIFO_DEPTH      4
`define FBS_FIFO_AW         2
`define FBS_FIFO_WIDTH      9
`define FBS_BYTE_W          8
`define FBS_BIT_CNT_W       3
`define FBS_BIT_LAST        3'h7
`define FBS_BIT_ZERO        3'h0
`define FBS_FIRST_POS       8
// one-hot transaction states
`define FBS_ST_IDLE         3'h1
`define FBS_ST_RECV         3'h2
`define FBS_ST_SEND         3'h4
// reset values and output enable patterns
`define FBS_BYTE_RST        8'h00
`define FBS_SYNC_RST        2'h3
`define FBS_SYNC_RST_LOW    2'h0
`define FBS_OE_OFF          8'h00
`define FBS_OE_ALL          8'hFF
`define FBS_OE_SO           8'h02
`endif

// file: design/fbs_fifo.v
`timescale 1ns/100ps
`include "fbs_defines.vh"
// ----------------------------------------------------------------
// small synchronous fifo, valid/ready on both sides
// ----------------------------------------------------------------
module fbs_fifo #(
    parameter WIDTH = `FBS_FIFO_WIDTH,
    parameter DEPTH = `FBS_FIFO_DEPTH,
    parameter AW    = `FBS_FIFO_AW
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             flush_in,
    // fill side
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    // drain side
    output wire [WIDTH-1:0] rd_data_out,
    output wire             rd_valid_out,
    input  wire             rd_ready_in
);
    reg  [WIDTH-1:0] mem_r [0:DEPTH-1]; // storage words
    reg  [AW-1:0]    wr_ptr_r;          // next write slot
    reg  [AW-1:0]    rd_ptr_r;          // next read slot
    reg  [AW:0]      count_r;           // words held
    wire             push;              // word accepted
    wire             pop;               // word delivered

    assign wr_ready_out = (count_r != DEPTH[AW:0]);
    assign rd_valid_out = (count_r != {(AW+1){1'b0}});
    assign rd_data_out  = mem_r[rd_ptr_r];
    assign push         = wr_valid_in & wr_ready_out;
    assign pop          = rd_valid_out & rd_ready_in;

    // storage write; no reset needed, count guards stale words
    always @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= wr_data_in;
        end
    end

    // pointers and occupancy; flush drops everything held
    always @(posedge clk_in) begin
        if (rst_in || flush_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_r <= count_r + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_r <= count_r - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// file: design/fbs_front.v
`timescale 1ns/100ps
`include "fbs_defines.vh"
module fbs_front (
    // clock and reset
    input  wire       clk_in,
    input  wire       sys_rst_in,
    // bus pins from the host
    input  wire       bus_select_n_in,
    input  wire       bus_clock_true_in,
    input  wire       bus_clock_complement_in,
    input  wire       hw_reset_n_in,
    input  wire [7:0] dq_in,
    // bus pins to the host
    output reg  [7:0] dq_out,
    output reg  [7:0] dq_oe_out,
    output reg        read_strobe_out,
    output reg        read_strobe_oe_out,
    // configuration
    input  wire       cfg_octal_mode_in,
    input  wire       cfg_diff_clock_in,
    // core status and control
    input  wire       embedded_busy_in,
    input  wire       read_phase_in,
    output reg        active_mode_out,
    output reg        standby_out,
    output reg        txn_start_out,
    output reg        txn_end_out,
    output reg        rx_overrun_out,
    // received byte stream
    output wire [7:0] rx_data_out,
    output wire       rx_first_out,
    output wire       rx_valid_out,
    input  wire       rx_ready_in,
    // read data from the core
    input  wire [7:0] tx_data_in,
    input  wire       tx_valid_in,
    output wire       tx_ready_out
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg  [1:0] sel_sync_r;            // select, reset to deselected
    reg  [1:0] ckt_sync_r;            // true clock
    reg  [1:0] ckc_sync_r;            // complement clock
    reg  [1:0] hwr_sync_r;            // hardware reset, idle high
    reg  [7:0] dq_s1_r;               // data first stage
    reg  [7:0] dq_s2_r;               // data second stage
    wire       sel_n;                 // synced select
    wire       rst;                   // combined internal reset

    // two flops on every pin; only stage two is read below
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            sel_sync_r <= `FBS_SYNC_RST;
            ckt_sync_r <= `FBS_SYNC_RST_LOW;
            ckc_sync_r <= `FBS_SYNC_RST_LOW;
            hwr_sync_r <= `FBS_SYNC_RST;
            dq_s1_r    <= `FBS_BYTE_RST;
            dq_s2_r    <= `FBS_BYTE_RST;
        end else begin
            sel_sync_r <= {sel_sync_r[0], bus_select_n_in};
            ckt_sync_r <= {ckt_sync_r[0], bus_clock_true_in};
            ckc_sync_r <= {ckc_sync_r[0], bus_clock_complement_in};
            hwr_sync_r <= {hwr_sync_r[0], hw_reset_n_in};
            dq_s1_r    <= dq_in;
            dq_s2_r    <= dq_s1_r;
        end
    end

    assign sel_n = sel_sync_r[1];
    // hardware reset pin reinitialises the front end past the pin synchronisers
    assign rst   = sys_rst_in | ~hwr_sync_r[1];

    // ----------------------------------------------------------------
    // select edges and mode latch
    // ----------------------------------------------------------------
    reg        sel_prev_r;            // select one cycle ago
    reg        octal_r;               // latched interface mode
    reg        diff_r;                // latched clock mode
    wire       sel_fall;              // transaction start
    wire       sel_rise;              // transaction end

    assign sel_fall = sel_prev_r & ~sel_n;
    assign sel_rise = ~sel_prev_r & sel_n;

    // modes sampled only at start so a mid-frame change cannot tear it
    always @(posedge clk_in) begin
        if (rst) begin
            sel_prev_r <= 1'b1;
            octal_r    <= 1'b0;
            diff_r     <= 1'b0;
        end else begin
            sel_prev_r <= sel_n;
            if (sel_fall) begin
                octal_r <= cfg_octal_mode_in;
                diff_r  <= cfg_diff_clock_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // clock edge finder
    // ----------------------------------------------------------------
    reg        ck_lvl_r;              // effective clock level seen
    reg        ck_prev_r;             // level one cycle ago
    reg        ck_lvl_nxt;            // next effective level
    wire       ck_rise;               // rising edge or crossing
    wire       ck_fall;               // falling edge or crossing

    // differential: level only moves when the pair truly disagrees,
    // so equal samples during a slow crossing hold the last state
    always @* begin
        ck_lvl_nxt = ck_lvl_r;
        if (!diff_r) begin
            ck_lvl_nxt = ckt_sync_r[1];
        end else if (ckt_sync_r[1] && !ckc_sync_r[1]) begin
            ck_lvl_nxt = 1'b1;
        end else if (!ckt_sync_r[1] && ckc_sync_r[1]) begin
            ck_lvl_nxt = 1'b0;
        end
    end

    // edges are only meaningful while selected
    always @(posedge clk_in) begin
        if (rst) begin
            ck_lvl_r  <= 1'b0;
            ck_prev_r <= 1'b0;
        end else begin
            ck_lvl_r  <= ck_lvl_nxt;
            ck_prev_r <= ck_lvl_r;
        end
    end

    assign ck_rise = ~sel_n & ck_lvl_r & ~ck_prev_r;
    assign ck_fall = ~sel_n & ~ck_lvl_r & ck_prev_r;

    // ----------------------------------------------------------------
    // transaction state machine
    // ----------------------------------------------------------------
    localparam ST_IDLE = `FBS_ST_IDLE;  // deselected
    localparam ST_RECV = `FBS_ST_RECV;  // command, address, write data
    localparam ST_SEND = `FBS_ST_SEND;  // read data out

    reg  [2:0] state_r;               // current state
    reg  [2:0] state_nxt;             // next state

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (sel_fall) begin
                    state_nxt = ST_RECV;
                end
            end
            ST_RECV: begin
                if (sel_n) begin
                    state_nxt = ST_IDLE;
                end else if (read_phase_in) begin
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                if (sel_n) begin
                    state_nxt = ST_IDLE;
                end else if (!read_phase_in) begin
                    state_nxt = ST_RECV;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // receive path
    // ----------------------------------------------------------------
    reg  [7:0] rx_shift_r;            // single-bit assembly
    reg  [2:0] rx_bits_r;             // bits gathered so far
    reg        rx_first_r;            // next byte opens the frame
    reg  [8:0] rx_word_r;             // word offered to the fifo
    reg        rx_push_r;             // offer strobe
    wire       fifo_ready;            // fifo has room
    wire       recv_on;               // capture allowed
    wire       fifo_flush;            // drop stale words

    assign recv_on    = (state_r == ST_RECV);
    // a new frame must never see leftovers of an aborted one
    assign fifo_flush = sel_fall;

    // single-bit: rising edge, line 0; eight-bit: every edge, all lines
    always @(posedge clk_in) begin
        if (rst || sel_rise || sel_n) begin
            rx_shift_r <= `FBS_BYTE_RST;
            rx_bits_r  <= `FBS_BIT_ZERO;
            rx_first_r <= 1'b1;
            rx_push_r  <= 1'b0;
            rx_word_r  <= {1'b0, `FBS_BYTE_RST};
        end else begin
            rx_push_r <= 1'b0;
            if (recv_on && !octal_r && ck_rise) begin
                rx_shift_r <= {rx_shift_r[6:0], dq_s2_r[0]};
                rx_bits_r  <= rx_bits_r + 3'h1;
                if (rx_bits_r == `FBS_BIT_LAST) begin
                    rx_word_r  <= {rx_first_r, rx_shift_r[6:0], dq_s2_r[0]};
                    rx_push_r  <= 1'b1;
                    rx_first_r <= 1'b0;
                end
            end else if (recv_on && octal_r && (ck_rise || ck_fall)) begin
                rx_word_r  <= {rx_first_r, dq_s2_r};
                rx_push_r  <= 1'b1;
                rx_first_r <= 1'b0;
            end
        end
    end

    // the host cannot be stalled, so a full fifo is reported, not hidden;
    // a drop that meets a frame start in one cycle still wins over the clear
    always @(posedge clk_in) begin
        if (rst) begin
            rx_overrun_out <= 1'b0;
        end else if (rx_push_r && !fifo_ready) begin
            rx_overrun_out <= 1'b1;
        end else if (sel_fall) begin
            rx_overrun_out <= 1'b0;
        end
    end

    fbs_fifo #(
        .WIDTH (`FBS_FIFO_WIDTH),
        .DEPTH (`FBS_FIFO_DEPTH),
        .AW    (`FBS_FIFO_AW)
    ) fbs_fifo_inst (
        .clk_in       (clk_in),
        .rst_in       (rst),
        .flush_in     (fifo_flush),
        .wr_data_in   (rx_word_r),
        .wr_valid_in  (rx_push_r),
        .wr_ready_out (fifo_ready),
        .rd_data_out  ({rx_first_out, rx_data_out}),
        .rd_valid_out (rx_valid_out),
        .rd_ready_in  (rx_ready_in)
    );

    // ----------------------------------------------------------------
    // send path and pin drivers
    // ----------------------------------------------------------------
    reg  [7:0] tx_shift_r;            // single-bit serialiser
    reg  [2:0] tx_bits_r;             // bits left after current
    wire       send_on;               // read phase active
    wire       tx_load;               // take a byte from the core

    assign send_on      = (state_r == ST_SEND);
    assign tx_load      = send_on & tx_valid_in &
                          (octal_r ? (ck_rise | ck_fall)
                                   : (ck_fall & (tx_bits_r == `FBS_BIT_ZERO)));
    assign tx_ready_out = tx_load;

    // drivers are flops; released whenever not in the read phase
    always @(posedge clk_in) begin
        if (rst || !send_on) begin
            dq_out             <= `FBS_BYTE_RST;
            dq_oe_out          <= `FBS_OE_OFF;
            read_strobe_out    <= 1'b0;
            read_strobe_oe_out <= 1'b0;
            tx_shift_r         <= `FBS_BYTE_RST;
            tx_bits_r          <= `FBS_BIT_ZERO;
        end else if (!octal_r) begin
            dq_oe_out          <= `FBS_OE_SO;
            read_strobe_oe_out <= 1'b0;
            if (ck_fall) begin
                if (tx_bits_r == `FBS_BIT_ZERO) begin
                    dq_out[1]  <= tx_valid_in ? tx_data_in[7] : 1'b0;
                    tx_shift_r <= tx_valid_in ? {tx_data_in[6:0], 1'b0} : `FBS_BYTE_RST;
                    tx_bits_r  <= tx_valid_in ? `FBS_BIT_LAST : `FBS_BIT_ZERO;
                end else begin
                    dq_out[1]  <= tx_shift_r[7];
                    tx_shift_r <= {tx_shift_r[6:0], 1'b0};
                    tx_bits_r  <= tx_bits_r - 3'h1;
                end
            end
        end else begin
            dq_oe_out          <= `FBS_OE_ALL;
            read_strobe_oe_out <= 1'b1;
            if (tx_load) begin
                dq_out          <= tx_data_in;
                read_strobe_out <= ~read_strobe_out;
            end
        end
    end

    // ----------------------------------------------------------------
    // mode and event outputs
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        if (rst) begin
            active_mode_out <= 1'b0;
            standby_out     <= 1'b1;
            txn_start_out   <= 1'b0;
            txn_end_out     <= 1'b0;
        end else begin
            active_mode_out <= ~sel_n;
            standby_out     <= sel_n & ~embedded_busy_in;
            txn_start_out   <= sel_fall;
            txn_end_out     <= sel_rise;
        end
    end
endmodule

// file: tb/fbs_front_properties.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checker for the flash bus front end
// ----------------------------------------------------------------
module fbs_front_checker (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       hw_reset_n_in,
    input wire logic       bus_select_n_in,
    input wire logic       read_phase_in,
    input wire logic       embedded_busy_in,
    input wire logic [7:0] dq_oe_out,
    input wire logic       read_strobe_out,
    input wire logic       read_strobe_oe_out,
    input wire logic       active_mode_out,
    input wire logic       standby_out,
    input wire logic       txn_start_out,
    input wire logic       txn_end_out,
    input wire logic       tx_ready_out
);
    // cycles since any reset; the pin synchronisers need a few edges to settle
    logic [3:0] rdy_cnt_r;
    wire        rdy = rdy_cnt_r[3];
    always @(posedge clk_in) begin
        if (sys_rst_in || !hw_reset_n_in) rdy_cnt_r <= 4'h0;
        else if (!rdy) rdy_cnt_r <= rdy_cnt_r + 4'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in || !hw_reset_n_in);
    chk_idle_release: assert property ((rdy && bus_select_n_in) [*5] |->
        dq_oe_out == 8'h00 && !read_strobe_oe_out && !active_mode_out) else $error("pins driven while idle");
    chk_active_select: assert property ((rdy && !bus_select_n_in) [*5] |-> active_mode_out)
        else $error("not active while selected");
    chk_standby_busy: assert property ((rdy && embedded_busy_in) [*2] |-> !standby_out)
        else $error("standby during busy");
    chk_standby_idle: assert property ((rdy && bus_select_n_in && !embedded_busy_in) [*5] |-> standby_out)
        else $error("no standby while idle");
    chk_start_pulse: assert property (rdy && $fell(bus_select_n_in) |-> ##[1:6] txn_start_out)
        else $error("no frame start");
    chk_end_pulse: assert property (rdy && $rose(bus_select_n_in) |-> ##[1:6] txn_end_out)
        else $error("no frame end");
    chk_wide_oe: assert property (read_strobe_oe_out |-> dq_oe_out == 8'hFF)
        else $error("strobe without all lines");
    chk_narrow_oe: assert property (dq_oe_out != 8'h00 && !read_strobe_oe_out |-> dq_oe_out == 8'h02)
        else $error("bad single line enable");
    chk_oe_read_only: assert property ((rdy && !read_phase_in) [*4] |-> dq_oe_out == 8'h00)
        else $error("drive outside read");
    chk_strobe_cause: assert property (rdy && read_strobe_oe_out && $rose(read_strobe_out) |->
        $past(tx_ready_out)) else $error("strobe without byte");
endmodule
bind fbs_front fbs_front_checker fbs_front_checker_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .hw_reset_n_in(hw_reset_n_in), .bus_select_n_in(bus_select_n_in), .read_phase_in(read_phase_in),
    .embedded_busy_in(embedded_busy_in), .dq_oe_out(dq_oe_out), .read_strobe_out(read_strobe_out),
    .read_strobe_oe_out(read_strobe_oe_out), .active_mode_out(active_mode_out), .standby_out(standby_out),
    .txn_start_out(txn_start_out), .txn_end_out(txn_end_out), .tx_ready_out(tx_ready_out));

// file: tb/fbs_front_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// front end testbench
// ----------------------------------------------------------------
module fbs_front_tb_top;
    logic       clk_in, sys_rst_in, hw_reset_n_in, cfg_octal_mode_in, cfg_diff_clock_in;
    logic       embedded_busy_in, read_phase_in, rx_ready_in, tx_valid_in, strb_prev, tx_adv;
    logic [7:0] tx_data_in, rnd;
    wire        sel_n, ck_t, ck_c, rd_st, rd_st_oe, act, stby, t_start, t_end, ovr, rx_first, rx_valid, tx_ready;
    wire  [7:0] host_dq, dq_o, dq_oe, rx_data, dq_in;
    logic [8:0] rxq[$];
    logic [7:0] txq[$];
    int         fails, n_checks, n_tx;
    // wire level: the device wins where it drives
    assign dq_in = (dq_oe & dq_o) | (~dq_oe & host_dq);
    fbs_front fbs_front_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_select_n_in(sel_n),
        .bus_clock_true_in(ck_t), .bus_clock_complement_in(ck_c), .hw_reset_n_in(hw_reset_n_in), .dq_in(dq_in),
        .dq_out(dq_o), .dq_oe_out(dq_oe), .read_strobe_out(rd_st), .read_strobe_oe_out(rd_st_oe),
        .cfg_octal_mode_in(cfg_octal_mode_in), .cfg_diff_clock_in(cfg_diff_clock_in),
        .embedded_busy_in(embedded_busy_in), .read_phase_in(read_phase_in), .active_mode_out(act),
        .standby_out(stby), .txn_start_out(t_start), .txn_end_out(t_end), .rx_overrun_out(ovr),
        .rx_data_out(rx_data), .rx_first_out(rx_first), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready_in),
        .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready));
    fbs_host_model host (.clk_in(clk_in), .diff_in(cfg_diff_clock_in), .dev_dq_in(dq_o), .sel_n_out(sel_n),
        .ck_t_out(ck_t), .ck_c_out(ck_c), .dq_out(host_dq));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic report(input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (e !== g) begin
            fails++;
            $display("[FAIL] %0t expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_rx(input logic [8:0] e, input logic [8:0] g); report(e, g); endtask
    task automatic chk_tx(input logic [7:0] e, input logic [7:0] g); report({1'b0, e}, {1'b0, g}); endtask
    task automatic chk_pin(input logic [7:0] e, input logic [7:0] g); report({1'b0, e}, {1'b0, g}); endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // results against the oldest note, as they appear
    always @(posedge clk_in) begin
        if (rx_valid === 1'b1 && rx_ready_in) chk_rx(rxq.pop_front(), {rx_first, rx_data});
        if (rd_st_oe === 1'b1 && rd_st !== strb_prev) begin
            n_tx++;
            chk_tx(txq.pop_front(), dq_o);
        end
        strb_prev <= rd_st;
        if (tx_ready === 1'b1 && tx_valid_in) begin
            txq.push_back(tx_data_in);
            tx_adv = 1'b1;
        end
    end
    always @(host.rd_ev) begin
        n_tx++;
        chk_tx(txq.pop_front(), host.rd_sr);
    end
    // core side: next read byte once the last was taken
    always @(negedge clk_in) if (tx_adv) begin
        tx_adv = 1'b0;
        tx_data_in = lfsr(tx_data_in);
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        {sys_rst_in, hw_reset_n_in, tx_valid_in, rx_ready_in} = 4'hF;
        {cfg_octal_mode_in, cfg_diff_clock_in, embedded_busy_in, read_phase_in, strb_prev, tx_adv} = 6'h00;
        tx_data_in = 8'h3B;
        rnd = 8'h3B;
        repeat (3) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        host.open_frame();
        host.put_x1(8'hFF, 3);
        host.close_frame();
        host.open_frame();
        cfg_octal_mode_in = 1'b1;
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            rxq.push_back({k == 0, rnd});
            host.put_x1(rnd, 8);
        end
        host.close_frame();
        for (int d = 0; d < 2; d++) begin
            cfg_diff_clock_in = d[0];
            host.open_frame();
            for (int k = 0; k < 4; k++) begin
                rnd = lfsr(rnd);
                rxq.push_back({k == 0, rnd});
                host.put_x8(rnd);
            end
            host.close_frame();
        end
        cfg_diff_clock_in = 1'b0;
        rx_ready_in = 1'b0;
        host.open_frame();
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            if (k < 4) rxq.push_back({k == 0, rnd});
            host.put_x8(rnd);
        end
        chk_pin(8'h01, {7'h00, ovr});
        host.close_frame();
        rx_ready_in = 1'b1;
        repeat (8) @(negedge clk_in);
        chk_pin(8'h00, 8'(rxq.size()));
        embedded_busy_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk_pin(8'h00, {7'h00, stby});
        embedded_busy_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk_pin(8'h01, {7'h00, stby});
        read_phase_in = 1'b1;
        host.open_frame();
        chk_pin(8'h00, {7'h00, ovr});
        chk_pin(8'hFF, dq_oe);
        repeat (4) host.edge_rd();
        hw_reset_n_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk_pin(8'h00, dq_oe | {7'h00, rd_st_oe});
        hw_reset_n_in = 1'b1;
        host.close_frame();
        chk_pin(8'h04, n_tx[7:0]);
        cfg_octal_mode_in = 1'b0;
        host.open_frame();
        chk_pin(8'h02, dq_oe);
        host.edge_rd();
        host.get_x1();
        host.get_x1();
        host.close_frame();
        read_phase_in = 1'b0;
        chk_pin(8'h06, n_tx[7:0]);
        chk_pin(8'h00, dq_oe);
        give_verdict();
    end
endmodule

// file: tb/fbs_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host controller model: select, clock pair, data lines
// ----------------------------------------------------------------
module fbs_host_model (
    input  wire logic       clk_in,
    input  wire logic       diff_in,
    input  wire logic [7:0] dev_dq_in,
    output logic            sel_n_out,
    output logic            ck_t_out,
    output logic            ck_c_out,
    output wire logic [7:0] dq_out
);
    logic [7:0] val_r;
    logic [7:0] noise_r;
    logic [7:0] drive_r;
    logic [7:0] rd_sr;
    event       rd_ev;
    initial begin
        sel_n_out = 1'b1;
        ck_t_out = 1'b0;
        ck_c_out = 1'b1;
        val_r = 8'h00;
        noise_r = 8'h5A;
        drive_r = 8'h00;
    end
    // released lines and a floating complement change every cycle
    always @(negedge clk_in) begin
        noise_r <= ~noise_r;
        if (!diff_in) ck_c_out <= ~ck_c_out;
    end
    assign dq_out = (val_r & drive_r) | (noise_r & ~drive_r);
    // one half period of the 400 ns link clock, data set one cycle ahead
    task automatic half(input logic lvl, input logic [7:0] d);
        val_r = d;
        @(negedge clk_in);
        ck_t_out = lvl;
        if (diff_in) ck_c_out = ~lvl;
        repeat (3) @(negedge clk_in);
        if (lvl) rd_sr = {rd_sr[6:0], dev_dq_in[1]};
    endtask
    task automatic open_frame;
        if (diff_in) ck_c_out = ~ck_t_out;
        sel_n_out = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask
    // edges after the select rise must be ignored
    task automatic close_frame;
        repeat (4) @(negedge clk_in);
        sel_n_out = 1'b1;
        drive_r = 8'h00;
        if (ck_t_out) half(1'b0, 8'h00);
        repeat (6) @(negedge clk_in);
    endtask
    task automatic put_x1(input logic [7:0] b, input int nbits);
        drive_r = 8'h01;
        for (int i = 7; i > 7 - nbits; i--) begin
            half(1'b1, {7'h00, b[i]});
            half(1'b0, {7'h00, b[i]});
        end
    endtask
    task automatic put_x8(input logic [7:0] b);
        drive_r = 8'hFF;
        half(~ck_t_out, b);
    endtask
    task automatic edge_rd;
        drive_r = 8'h00;
        half(~ck_t_out, 8'h00);
    endtask
    task automatic get_x1;
        drive_r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            half(1'b0, 8'h00);
            half(1'b1, 8'h00);
        end
        ->rd_ev;
    endtask
endmodule
